// ---- core/uir_pkg.sv ----
// shared constants and types for the uart interrupt id / flow threshold bank
package uir_pkg;

  // ----------------------------------------------------------------
  // register indices on the internal register port
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_INT_ENABLE = 3'h0;
  localparam logic [2:0] IDX_FIFO_CTRL = 3'h1; // write fifo_control, read id
  localparam logic [2:0] IDX_MODEM_CTRL = 3'h2;
  localparam logic [2:0] IDX_ENH_FEATURE = 3'h3;
  localparam logic [2:0] IDX_DIV_LOW = 3'h4;
  localparam logic [2:0] IDX_DIV_HIGH = 3'h5;
  localparam logic [2:0] IDX_HALT_RESUME = 3'h6;
  localparam logic [2:0] IDX_TRIG_LEVELS = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int IE_RX_DATA = 0;
  localparam int IE_TX_HOLD = 1;
  localparam int IE_LINE = 2;
  localparam int IE_MODEM = 3;
  localparam int IE_SLEEP = 4;
  localparam int IE_XOFF = 5;
  localparam int IE_RTS = 6;
  localparam int IE_CTS = 7;
  localparam int FC_ENABLE = 0;
  localparam int MC_RTS = 1;
  localparam int MC_LVL_ACCESS = 2;
  localparam int EF_AUTO_CTS = 7;
  localparam int EF_AUTO_RTS = 6;
  localparam int EF_SPECIAL = 5;
  localparam int EF_ENHANCED = 4;
  localparam logic [7:0] IE_ENH_MASK = 8'hF0;
  localparam logic [7:0] FC_ENH_MASK = 8'h30;
  localparam logic [7:0] MC_ENH_MASK = 8'hE0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // interrupt source codes, bits 5:0 of the id register
  // ----------------------------------------------------------------
  localparam logic [5:0] ID_NONE = 6'h01;
  localparam logic [5:0] ID_LINE = 6'h06;
  localparam logic [5:0] ID_RX_TIMEOUT = 6'h0C;
  localparam logic [5:0] ID_RX_DATA = 6'h04;
  localparam logic [5:0] ID_TX_HOLD = 6'h02;
  localparam logic [5:0] ID_MODEM = 6'h00;
  localparam logic [5:0] ID_PIN_CHANGE = 6'h30;
  localparam logic [5:0] ID_SPECIAL = 6'h10;
  localparam logic [5:0] ID_CTS_RTS = 6'h20;

  // pending vector order, bit 0 highest priority
  typedef struct packed {
    logic cts_rts;
    logic special;
    logic pin_change;
    logic modem;
    logic tx_hold;
    logic rx_data;
    logic rx_timeout;
    logic line;
  } uir_pend_s;

  // threshold fields count in steps of four characters
  localparam int LVL_SHIFT = 2;

  typedef struct packed {
    logic [7:0] int_enable;
    logic [7:0] fifo_control;
    logic [7:0] modem_control;
    logic [7:0] enhanced_feature_ctrl;
    logic [7:0] baud_divisor_low;
    logic [7:0] baud_divisor_high;
    logic [7:0] flow_halt_resume_levels;
    logic [7:0] fifo_trigger_levels;
    logic cts_rts_flag;
    logic special_flag;
    logic cts_n_prev;
    logic rts_n;
    logic [7:0] rdata;
  } uir_state_s;

endpackage : uir_pkg

// ---- core/uir_prio_enc.sv ----
// priority encoder for the interrupt source code
`timescale 1ns/1ps
module uir_prio_enc (
  input wire uir_pkg::uir_pend_s pend,
  output logic [5:0] code
);
  always_comb begin
    if (pend.line) begin // [R4]
      code = uir_pkg::ID_LINE;
    end else if (pend.rx_timeout) begin
      code = uir_pkg::ID_RX_TIMEOUT;
    end else if (pend.rx_data) begin
      code = uir_pkg::ID_RX_DATA;
    end else if (pend.tx_hold) begin
      code = uir_pkg::ID_TX_HOLD;
    end else if (pend.modem) begin
      code = uir_pkg::ID_MODEM; // [R6]
    end else if (pend.pin_change) begin
      code = uir_pkg::ID_PIN_CHANGE; // [R6]
    end else if (pend.special) begin
      code = uir_pkg::ID_SPECIAL;
    end else if (pend.cts_rts) begin
      code = uir_pkg::ID_CTS_RTS;
    end else begin
      code = uir_pkg::ID_NONE; // [R1] [R22]
    end
  end
endmodule : uir_prio_enc

// ---- core/uir_regs.sv ----
// interrupt id, enhanced feature, divisor and fifo threshold registers
// ----------------------------------------------------------------
// Notes on behaviour
// [R1] id bit 0 reads 0 while an interrupt pends, 1 otherwise.
// [R2] id bits 7:6 both copy the fifo enable bit.
// [R3] id bits 5:1 hold the encoded source code per source.
// [R4] only the highest-priority pending source is reported.
// [R5] cts or rts going low to high raises the lowest source.
// [R6] modem and pin-change are marked by code only; host reads detail.
// [R7] auto-cts on: transmitter halts while cts input is high.
// [R8] auto-rts on: rts high at halt level, low at resume level.
// [R9] special detect on: match second stop char, flag id bit 4.
// [R10] enhanced enable gates writes to ie 7:4, fc 5:4, mc 7:5.
// [R11] feature bits 3:0 select software flow-control combination.
// [R12] baud divisor is high byte and low byte, 16 bits.
// [R13] divisor writes only while sleep enable is clear.
// [R14] halt/resume fields mean four times the field value.
// [R15] halt/resume writes need enhanced enable and modem bit 2.
// [R16] host keeps halt above resume; device does not check.
// [R17] trigger register: upper nibble rx, lower nibble tx, times four.
// [R18] trigger writes need enhanced enable and modem bit 2.
// [R19] zero nibble falls back to the fifo control trigger choice.
// [R20] host leaves fifo control 7:6 at 00 when trigger reg rules rx.
// [R21] only enabled sources reach irq and the id code; the cts/rts flag, once set, stays reported after its enables clear.
// [R22] id tracks pending sources live; none left reads no interrupt.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module uir_regs #(
  // fifo control trigger table, index fifo_control 7:6 / 5:4
  parameter logic [6:0] RX_FC_TRIG0 = 7'h08,
  parameter logic [6:0] RX_FC_TRIG1 = 7'h10,
  parameter logic [6:0] RX_FC_TRIG2 = 7'h38,
  parameter logic [6:0] RX_FC_TRIG3 = 7'h3C,
  parameter logic [6:0] TX_FC_TRIG0 = 7'h08,
  parameter logic [6:0] TX_FC_TRIG1 = 7'h10,
  parameter logic [6:0] TX_FC_TRIG2 = 7'h20,
  parameter logic [6:0] TX_FC_TRIG3 = 7'h38
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic src_line,
  input wire logic src_rx_timeout,
  input wire logic src_rx_data,
  input wire logic src_tx_hold,
  input wire logic src_modem,
  input wire logic src_pin_change,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic [7:0] second_stop_char,
  input wire logic cts_n,
  input wire logic [6:0] rx_fifo_level,
  output logic irq_n,
  output logic rts_n,
  output logic tx_halt,
  output logic [15:0] baud_divisor,
  output logic [3:0] sw_flow_select,
  output logic [6:0] rx_trigger,
  output logic [6:0] tx_trigger,
  output logic [7:0] int_enable,
  output logic [7:0] fifo_control,
  output logic [7:0] modem_control
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  uir_pkg::uir_state_s st_ff;
  uir_pkg::uir_state_s nxt_st;
  uir_pkg::uir_pend_s pend;
  logic [5:0] id_code;
  logic [7:0] id_value;
  logic enh;
  logic lvl_access;
  logic [6:0] halt_lvl;
  logic [6:0] resume_lvl;
  logic rts_rise;
  logic cts_rise;
  logic nxt_rts_n;
  logic id_read;

  assign enh = st_ff.enhanced_feature_ctrl[uir_pkg::EF_ENHANCED];
  assign lvl_access = enh & st_ff.modem_control[uir_pkg::MC_LVL_ACCESS];
  // field value times four, range 0..60
  assign halt_lvl = {1'b0, st_ff.flow_halt_resume_levels[3:0], 2'b00}; // [R14]
  assign resume_lvl = {1'b0, st_ff.flow_halt_resume_levels[7:4],
                       2'b00}; // [R14]

  // ----------------------------------------------------------------
  // interrupt sources, gated by their enables
  // ----------------------------------------------------------------
  always_comb begin
    pend.line = src_line & st_ff.int_enable[uir_pkg::IE_LINE]; // [R21]
    pend.rx_timeout = src_rx_timeout & st_ff.int_enable[uir_pkg::IE_RX_DATA];
    pend.rx_data = src_rx_data & st_ff.int_enable[uir_pkg::IE_RX_DATA];
    pend.tx_hold = src_tx_hold & st_ff.int_enable[uir_pkg::IE_TX_HOLD];
    pend.modem = src_modem & st_ff.int_enable[uir_pkg::IE_MODEM];
    // pin-change arrives already gated by the gpio interrupt enables
    pend.pin_change = src_pin_change;
    pend.special = st_ff.special_flag & st_ff.int_enable[uir_pkg::IE_XOFF];
    // cts/rts enables gate the setting of this flag, not its report
    pend.cts_rts = st_ff.cts_rts_flag;
  end

  // ----------------------------------------------------------------
  // interrupt id
  // ----------------------------------------------------------------
  uir_prio_enc u_enc (
    .pend(pend),
    .code(id_code)
  );

  assign id_value = {{2{st_ff.fifo_control[uir_pkg::FC_ENABLE]}}, // [R2]
                     id_code[5:1], id_code[0]}; // [R3] [R1]

  // ----------------------------------------------------------------
  // auto rts with hysteresis between halt and resume levels
  // ----------------------------------------------------------------
  always_comb begin
    // between the two levels the pin keeps its state
    nxt_rts_n = st_ff.rts_n;
    if (st_ff.enhanced_feature_ctrl[uir_pkg::EF_AUTO_RTS]) begin
      if (rx_fifo_level >= halt_lvl) begin // [R8]
        nxt_rts_n = 1'b1;
      end else if (rx_fifo_level <= resume_lvl) begin // [R8]
        nxt_rts_n = 1'b0;
      end
    end else begin
      nxt_rts_n = ~st_ff.modem_control[uir_pkg::MC_RTS];
    end
  end

  // ----------------------------------------------------------------
  // inactive-going edges of cts and rts
  // ----------------------------------------------------------------
  // rts edge taken on the level about to be driven, kept out of the
  // next-state process so the detector never reads back its own output
  assign cts_rise = cts_n & ~st_ff.cts_n_prev &
                    st_ff.int_enable[uir_pkg::IE_CTS];
  assign rts_rise = nxt_rts_n & ~st_ff.rts_n &
                    st_ff.int_enable[uir_pkg::IE_RTS];
  assign id_read = reg_rd & (reg_addr == uir_pkg::IDX_FIFO_CTRL);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cts_n_prev = cts_n;

    // host writes
    if (reg_wr) begin
      case (reg_addr)
        uir_pkg::IDX_INT_ENABLE: begin
          nxt_st.int_enable = enh ? reg_wdata : // [R10]
            (st_ff.int_enable & uir_pkg::IE_ENH_MASK) |
            (reg_wdata & ~uir_pkg::IE_ENH_MASK);
        end
        uir_pkg::IDX_FIFO_CTRL: begin
          nxt_st.fifo_control = enh ? reg_wdata : // [R10]
            (st_ff.fifo_control & uir_pkg::FC_ENH_MASK) |
            (reg_wdata & ~uir_pkg::FC_ENH_MASK);
        end
        uir_pkg::IDX_MODEM_CTRL: begin
          nxt_st.modem_control = enh ? reg_wdata : // [R10]
            (st_ff.modem_control & uir_pkg::MC_ENH_MASK) |
            (reg_wdata & ~uir_pkg::MC_ENH_MASK);
        end
        uir_pkg::IDX_ENH_FEATURE: begin
          nxt_st.enhanced_feature_ctrl = reg_wdata; // [R11]
        end
        uir_pkg::IDX_DIV_LOW: begin
          if (!st_ff.int_enable[uir_pkg::IE_SLEEP]) begin // [R13]
            nxt_st.baud_divisor_low = reg_wdata;
          end
        end
        uir_pkg::IDX_DIV_HIGH: begin
          if (!st_ff.int_enable[uir_pkg::IE_SLEEP]) begin // [R13]
            nxt_st.baud_divisor_high = reg_wdata;
          end
        end
        uir_pkg::IDX_HALT_RESUME: begin
          // ordering of halt above resume is left to the host
          if (lvl_access) begin // [R15] [R16]
            nxt_st.flow_halt_resume_levels = reg_wdata;
          end
        end
        uir_pkg::IDX_TRIG_LEVELS: begin
          if (lvl_access) begin // [R18]
            nxt_st.fifo_trigger_levels = reg_wdata;
          end
        end
        default: begin
          nxt_st.rdata = st_ff.rdata;
        end
      endcase
    end

    nxt_st.rts_n = nxt_rts_n;

    // sticky flags: reading the id clears, a new event in the same
    // cycle wins so it is never lost
    if (id_read) begin
      nxt_st.cts_rts_flag = 1'b0;
      nxt_st.special_flag = 1'b0;
    end
    if (cts_rise | rts_rise) begin // [R5]
      nxt_st.cts_rts_flag = 1'b1;
    end
    if (rx_char_valid && st_ff.enhanced_feature_ctrl[uir_pkg::EF_SPECIAL] &&
        rx_char == second_stop_char) begin // [R9]
      nxt_st.special_flag = 1'b1;
    end

    // read data, captured only on a read strobe so it stands until
    // the next read
    case (reg_addr)
      uir_pkg::IDX_INT_ENABLE: nxt_st.rdata = st_ff.int_enable;
      uir_pkg::IDX_FIFO_CTRL: nxt_st.rdata = id_value; // [R22]
      uir_pkg::IDX_MODEM_CTRL: nxt_st.rdata = st_ff.modem_control;
      uir_pkg::IDX_ENH_FEATURE: nxt_st.rdata = st_ff.enhanced_feature_ctrl;
      uir_pkg::IDX_DIV_LOW: nxt_st.rdata = st_ff.baud_divisor_low;
      uir_pkg::IDX_DIV_HIGH: nxt_st.rdata = st_ff.baud_divisor_high;
      uir_pkg::IDX_HALT_RESUME: nxt_st.rdata = st_ff.flow_halt_resume_levels;
      uir_pkg::IDX_TRIG_LEVELS: nxt_st.rdata = st_ff.fifo_trigger_levels;
      default: nxt_st.rdata = uir_pkg::REG_RESET;
    endcase
    if (!reg_rd) begin
      nxt_st.rdata = st_ff.rdata;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{
        int_enable: uir_pkg::REG_RESET,
        fifo_control: uir_pkg::REG_RESET,
        modem_control: uir_pkg::REG_RESET,
        enhanced_feature_ctrl: uir_pkg::REG_RESET,
        baud_divisor_low: uir_pkg::REG_RESET,
        baud_divisor_high: uir_pkg::REG_RESET,
        flow_halt_resume_levels: uir_pkg::REG_RESET,
        fifo_trigger_levels: uir_pkg::REG_RESET,
        cts_rts_flag: 1'b0,
        special_flag: 1'b0,
        // detector starts as if cts were inactive: no false edge
        cts_n_prev: 1'b1,
        rts_n: 1'b1,
        rdata: uir_pkg::REG_RESET
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    case (st_ff.fifo_control[7:6])
      2'h0: rx_trigger = RX_FC_TRIG0;
      2'h1: rx_trigger = RX_FC_TRIG1;
      2'h2: rx_trigger = RX_FC_TRIG2;
      default: rx_trigger = RX_FC_TRIG3;
    endcase
    case (st_ff.fifo_control[5:4])
      2'h0: tx_trigger = TX_FC_TRIG0;
      2'h1: tx_trigger = TX_FC_TRIG1;
      2'h2: tx_trigger = TX_FC_TRIG2;
      default: tx_trigger = TX_FC_TRIG3;
    endcase
    // a non-zero nibble overrides the fifo control choice
    if (st_ff.fifo_trigger_levels[7:4] != 4'h0) begin // [R19]
      rx_trigger = {1'b0, st_ff.fifo_trigger_levels[7:4], 2'b00}; // [R17]
    end
    if (st_ff.fifo_trigger_levels[3:0] != 4'h0) begin // [R19]
      tx_trigger = {1'b0, st_ff.fifo_trigger_levels[3:0], 2'b00}; // [R17]
    end
  end

  // ----------------------------------------------------------------
  // pins and register copies
  // ----------------------------------------------------------------
  assign irq_n = id_code[0]; // [R21]
  assign rts_n = st_ff.rts_n;
  // combinational so a cts change stops the next character at once
  assign tx_halt = st_ff.enhanced_feature_ctrl[uir_pkg::EF_AUTO_CTS] &
                   cts_n; // [R7]
  assign baud_divisor = {st_ff.baud_divisor_high,
                         st_ff.baud_divisor_low}; // [R12]
  assign sw_flow_select = st_ff.enhanced_feature_ctrl[3:0]; // [R11]
  assign reg_rdata = st_ff.rdata;
  assign int_enable = st_ff.int_enable;
  assign fifo_control = st_ff.fifo_control;
  assign modem_control = st_ff.modem_control;

endmodule : uir_regs

// ---- tb/uir_regs_chk.sv ----
// port assertions for the interrupt id and threshold register bank
`timescale 1ns/1ps
module uir_regs_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic src_line,
  input wire logic src_pin_change,
  input wire logic cts_n,
  input wire logic irq_n,
  input wire logic tx_halt,
  input wire logic [15:0] baud_divisor,
  input wire logic [6:0] rx_trigger,
  input wire logic [7:0] int_enable,
  input wire logic [7:0] fifo_control
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic id_rd;
  assign id_rd = reg_rd && reg_addr == uir_pkg::IDX_FIFO_CTRL;
  idle_flag_a: assert property ($past(id_rd) |->
    reg_rdata[0] == $past(irq_n)) else $error("id bit 0 wrong");
  fifo_mirror_a: assert property ($past(id_rd) |->
    reg_rdata[7:6] == {2{$past(fifo_control[0])}}) else $error("mirror");
  line_first_a: assert property (
    $past(id_rd && src_line && int_enable[2]) |->
    reg_rdata[5:0] == uir_pkg::ID_LINE) else $error("line code");
  line_irq_a: assert property (src_line && int_enable[2] |-> !irq_n)
    else $error("line irq missing");
  quiet_irq_a: assert property (int_enable == 8'h00 && !src_pin_change
    |-> irq_n) else $error("irq without enable");
  cts_halt_a: assert property (tx_halt |-> cts_n) else $error("halt");
  div_gate_a: assert property ($changed(baud_divisor) |->
    $past(reg_wr && !int_enable[4])) else $error("divisor gate");
  div_high_a: assert property ($changed(baud_divisor[15:8]) |->
    $past(reg_wr && reg_addr == uir_pkg::IDX_DIV_HIGH) &&
    baud_divisor[15:8] == $past(reg_wdata)) else $error("divisor high");
  ie_gate_a: assert property ($changed(int_enable) |->
    $past(reg_wr && reg_addr == uir_pkg::IDX_INT_ENABLE)) else $error("ie");
  trig_step_a: assert property (rx_trigger[1:0] == 2'h0)
    else $error("trigger step");
  cover property (id_rd && src_line && int_enable[2]);
  cover property (tx_halt);
  cover property ($changed(baud_divisor));
endmodule : uir_regs_chk

// ---- tb/uir_host.sv ----
// host model driving the register port at the falling edge
`timescale 1ns/1ps
module uir_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [2:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // stale data inverted so a late sample shows up
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : uir_host

// ---- tb/uir_regs_bench.sv ----
// self-checking bench for the interrupt id and threshold register bank
`timescale 1ns/1ps
module uir_regs_bench;
  logic clk, rst, rd_s, wr_s, cv, cts_n, irq_n, rts_n, tx_halt;
  logic [2:0] addr;
  logic [7:0] wd, rdat, ch, d, ie, fc, mc;
  logic [5:0] src;
  logic [6:0] lvl, rxt, txt;
  logic [15:0] div;
  logic [3:0] sfs;
  int err_total, n_checks, cyc;
  logic [5:0] codes [7] = '{uir_pkg::ID_LINE, uir_pkg::ID_RX_TIMEOUT,
    uir_pkg::ID_RX_DATA, uir_pkg::ID_TX_HOLD, uir_pkg::ID_MODEM,
    uir_pkg::ID_PIN_CHANGE, uir_pkg::ID_NONE};
  uir_host u_host (.clk(clk), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat));
  uir_regs u_dut (.clk(clk), .rst(rst), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat), .src_line(src[0]),
    .src_rx_timeout(src[1]), .src_rx_data(src[2]), .src_tx_hold(src[3]),
    .src_modem(src[4]), .src_pin_change(src[5]), .rx_char_valid(cv),
    .rx_char(ch), .second_stop_char(8'h13), .cts_n(cts_n),
    .rx_fifo_level(lvl), .irq_n(irq_n), .rts_n(rts_n), .tx_halt(tx_halt),
    .baud_divisor(div), .sw_flow_select(sfs), .rx_trigger(rxt),
    .tx_trigger(txt), .int_enable(ie), .fifo_control(fc),
    .modem_control(mc));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    clk = 0; rst = 1; src = 6'h00; cv = 0; ch = 8'h00; cts_n = 0;
    lvl = 7'h00;
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 0;
    u_host.rd(uir_pkg::IDX_FIFO_CTRL, d);
    chk(d, 16'h0001);
    chk(irq_n, 16'h0001);
    chk(div, 16'h0000);
    $display("test reset done");
    // divisor must be set before sleep enable goes up
    u_host.wr(uir_pkg::IDX_DIV_LOW, 8'h34);
    u_host.wr(uir_pkg::IDX_DIV_HIGH, 8'h12);
    chk(div, 16'h1234);
    u_host.wr(uir_pkg::IDX_INT_ENABLE, 8'hFF);
    chk(ie, 16'h000F);
    u_host.wr(uir_pkg::IDX_MODEM_CTRL, 8'hE0);
    chk(mc, 16'h0000);
    u_host.wr(uir_pkg::IDX_ENH_FEATURE, 8'h10);
    u_host.wr(uir_pkg::IDX_INT_ENABLE, 8'h1F);
    u_host.wr(uir_pkg::IDX_DIV_LOW, 8'h55);
    chk(div, 16'h1234);
    u_host.wr(uir_pkg::IDX_INT_ENABLE, 8'h0F);
    u_host.wr(uir_pkg::IDX_FIFO_CTRL, 8'h31);
    chk(fc, 16'h0031);
    $display("test gating done");
    src = 6'h3F;
    for (int i = 0; i < 7; i++) begin
      u_host.rd(uir_pkg::IDX_FIFO_CTRL, d);
      chk(d, {8'h00, 2'b11, codes[i]});
      chk(irq_n, 16'(i == 6));
      if (i < 6) src[i] = 1'b0;
    end
    $display("test priority done");
    // fifo control 7:6 stays 00 while the trigger register rules rx
    u_host.wr(uir_pkg::IDX_TRIG_LEVELS, 8'h53);
    chk(rxt, 16'h0008);
    u_host.wr(uir_pkg::IDX_HALT_RESUME, 8'h13);
    u_host.rd(uir_pkg::IDX_HALT_RESUME, d);
    chk(d, 16'h0000);
    u_host.wr(uir_pkg::IDX_MODEM_CTRL, 8'h06);
    u_host.wr(uir_pkg::IDX_TRIG_LEVELS, 8'h53);
    chk({rxt, 1'b0, txt}, {7'h14, 1'b0, 7'h0C});
    u_host.wr(uir_pkg::IDX_TRIG_LEVELS, 8'h50);
    chk(txt, 16'h0038);
    // halt above resume before auto rts goes on
    u_host.wr(uir_pkg::IDX_HALT_RESUME, 8'h13);
    u_host.wr(uir_pkg::IDX_INT_ENABLE, 8'h4F);
    chk(rts_n, 16'h0000);
    u_host.wr(uir_pkg::IDX_ENH_FEATURE, 8'hD0);
    lvl = 7'h0C;
    repeat (2) @(negedge clk);
    chk(rts_n, 16'h0001);
    u_host.rd(uir_pkg::IDX_FIFO_CTRL, d);
    chk(d, 16'h00E0);
    lvl = 7'h08;
    repeat (2) @(negedge clk);
    chk(rts_n, 16'h0001);
    lvl = 7'h04;
    repeat (2) @(negedge clk);
    chk(rts_n, 16'h0000);
    chk(tx_halt, 16'h0000);
    cts_n = 1;
    @(negedge clk);
    chk(tx_halt, 16'h0001);
    cts_n = 0;
    $display("test flow done");
    u_host.wr(uir_pkg::IDX_ENH_FEATURE, 8'h33);
    chk(sfs, 16'h0003);
    u_host.wr(uir_pkg::IDX_INT_ENABLE, 8'hA0);
    ch = 8'h13;
    cv = 1;
    @(negedge clk);
    cv = 0;
    u_host.rd(uir_pkg::IDX_FIFO_CTRL, d);
    chk(d, 16'h00D0);
    cts_n = 1;
    repeat (3) @(negedge clk);
    chk(tx_halt, 16'h0000);
    u_host.rd(uir_pkg::IDX_FIFO_CTRL, d);
    chk(d, 16'h00E0);
    u_host.rd(uir_pkg::IDX_FIFO_CTRL, d);
    chk(d, 16'h00C1);
    chk(irq_n, 16'h0001);
    $display("test flags done");
    end_of_test();
  end
endmodule : uir_regs_bench
bind uir_regs uir_regs_chk u_chk (.clk(clk), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .src_line(src_line),
  .src_pin_change(src_pin_change), .cts_n(cts_n), .irq_n(irq_n),
  .tx_halt(tx_halt), .baud_divisor(baud_divisor), .rx_trigger(rx_trigger),
  .int_enable(int_enable), .fifo_control(fifo_control));
